/* File: hdl/ccc_ctrl.v */
/*
 Control and monitor logic of the processor instruction cache: cacheable
 windows, flush sequencing, debug access gating of the mirrored RAM,
 refill options and the miss rate monitor, reached over APB.
 Assumes all inputs come from logic on CLK and word-only APB access.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ccc_defs.vh"

module ccc_ctrl (
   input  wire        CLK,
   input  wire        RST_B,
   input  wire        CE,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [31:0] PADDR,
   input  wire [31:0] PWDATA,
   input  wire [3:0]  PSTRB,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   input  wire        CACHE_ENABLE,
   input  wire        STORE_RAM_SELECTOR,
   input  wire        LOOKUP_VALID,
   input  wire [31:0] LOOKUP_ADDR,
   input  wire        LOOKUP_HIT,
   input  wire        LOOKUP_HIT_WS,
   output reg         CACHEABLE,
   output reg         QSPI_SELECT,
   input  wire        MIRROR_VALID,
   input  wire        MIRROR_WRITE,
   input  wire [15:0] MIRROR_ADDR,
   input  wire [1:0]  MIRROR_SIZE,
   output reg         MIRROR_ALLOW,
   output reg         MIRROR_ERROR,
   output reg         CACHE_READY,
   output reg         FLUSH_ACTIVE,
   output reg  [7:0]  FLUSH_INDEX,
   output reg         MONITOR_IRQ,
   output reg         DEBUG_RESET_REQ,
   output reg  [26:0] CTRL_TWO
);

   // ==========================================================
   // State
   reg [31:0] hit_tally;
   reg [31:0] miss_tally;
   reg [31:0] hit_ws_tally;
   reg [31:0] miss_thr;
   reg [31:0] hit_thr;
   reg [31:0] qspi_cfg;
   reg [31:0] emb_cfg;
   reg [`CCC_MON_W-1:0]  mon_ctrl;
   reg [`CCC_TINT_W-1:0] tint;
   reg [`CCC_TINT_W-1:0] tint_cnt;
   reg [6:0]  ref_acc;
   reg [8:0]  flush_cnt;
   reg        initialised;
   reg        selector_prev;

   // ==========================================================
   // Helpers
   function in_window;
      input [31:0] addr;
      input [15:0] base;
      input [8:0]  blocks;
      reg   [31:0] rel;
      begin
         rel = addr - {base, 16'h0000};
         in_window = (blocks != 9'h000) &&
                     (rel[31:16] < {7'h00, blocks});
      end
   endfunction

   function [31:0] bump;
      input [31:0] value;
      begin
         bump = value + 32'h0000_0001;
      end
   endfunction

   // ==========================================================
   // Lookup classification
   wire [8:0] qspi_blocks = CTRL_TWO[`CCC_QSPI_LEN_HI:`CCC_QSPI_LEN_LO];
   wire [8:0] emb_blocks  = CTRL_TWO[`CCC_EMB_LEN_HI:`CCC_EMB_LEN_LO];
   // Offset is inside a window when its 64 KB block number is below the
   // window's block count; it is measured from the region base
   wire in_qspi = in_window(LOOKUP_ADDR, qspi_cfg[31:16], qspi_blocks);
   wire in_emb  = in_window(LOOKUP_ADDR, emb_cfg[31:16], emb_blocks);
   wire lookup_cacheable = in_qspi | in_emb;
   wire run = mon_ctrl[`CCC_MON_RUN];
   wire count_hit  = run & LOOKUP_VALID & lookup_cacheable & LOOKUP_HIT;
   wire count_miss = run & LOOKUP_VALID & lookup_cacheable & ~LOOKUP_HIT;
   wire count_ws   = count_hit & LOOKUP_HIT_WS;

   // ==========================================================
   // Reference tick of 32 MHz from the 100 MHz clock
   // One spare bit: accumulator plus step can pass 127
   wire [7:0] acc_sum = {1'b0, ref_acc} + {1'b0, `CCC_REF_MHZ};
   wire       ref_tick = (acc_sum >= {1'b0, `CCC_CLK_MHZ});
   wire [7:0] acc_wrap = acc_sum - {1'b0, `CCC_CLK_MHZ};
   wire [6:0] next_ref_acc = ref_tick ? acc_wrap[6:0] : acc_sum[6:0];
   wire       tint_expire = run & ref_tick & (tint != 0) &
                            (tint_cnt <= 19'h00001);

   // ==========================================================
   // APB decode
   wire apb_setup  = PSEL & ~PENABLE;
   wire apb_access = PSEL & PENABLE & PREADY;
   wire wr = apb_access & PWRITE & ~PSLVERR;
   reg  addr_hit;
   reg  [31:0] rd_value;
   always @* begin
      addr_hit = 1'b1;
      rd_value = 32'h0000_0000;
      case (PADDR)
         `CCC_A_CTRL_TWO: rd_value = {3'h0, CACHE_READY, FLUSH_ACTIVE,
                                      CTRL_TWO};
         `CCC_A_HIT:      rd_value = hit_tally;
         `CCC_A_MISS:     rd_value = miss_tally;
         `CCC_A_MON_CTRL: rd_value = {27'h0, mon_ctrl};
         `CCC_A_TINT:     rd_value = {13'h0, tint};
         `CCC_A_MISS_THR: rd_value = miss_thr;
         `CCC_A_HIT_THR:  rd_value = hit_thr;
         `CCC_A_QSPI_CFG: rd_value = qspi_cfg;
         `CCC_A_EMB_CFG:  rd_value = emb_cfg;
         `CCC_A_HIT_WS:   rd_value = hit_ws_tally;
         `CCC_A_DBG_RST:  rd_value = 32'h0000_0000;
         default:         addr_hit = 1'b0;
      endcase
   end

   // Answer one cycle into the access phase; narrow writes are refused
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         if (PSEL & PENABLE & ~PREADY) begin
            PREADY  <= 1'b1;
            PRDATA  <= (PWRITE | ~addr_hit) ? 32'h0000_0000 : rd_value;
            PSLVERR <= ~addr_hit |
                       (PWRITE & (PSTRB != `CCC_WORD_STRB));
         end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
         end
      end
   end

   wire w_ctrl  = wr & (PADDR == `CCC_A_CTRL_TWO);
   wire w_hit   = wr & (PADDR == `CCC_A_HIT);
   wire w_miss  = wr & (PADDR == `CCC_A_MISS);
   wire w_mon   = wr & (PADDR == `CCC_A_MON_CTRL);
   wire w_tint  = wr & (PADDR == `CCC_A_TINT);
   wire w_mthr  = wr & (PADDR == `CCC_A_MISS_THR);
   wire w_hthr  = wr & (PADDR == `CCC_A_HIT_THR);
   wire w_qcfg  = wr & (PADDR == `CCC_A_QSPI_CFG);
   wire w_ecfg  = wr & (PADDR == `CCC_A_EMB_CFG);
   wire w_hws   = wr & (PADDR == `CCC_A_HIT_WS);
   wire w_dbg   = wr & (PADDR == `CCC_A_DBG_RST);

   // ==========================================================
   // Monitor counters and status
   wire [31:0] hit_next  = bump(hit_tally);
   wire [31:0] miss_next = bump(miss_tally);
   wire hit_thr_evt  = count_hit & (hit_thr != 0) & (hit_next == hit_thr);
   wire miss_thr_evt = count_miss & (miss_thr != 0) &
                       (miss_next == miss_thr);

   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         hit_tally    <= 32'h0000_0000;
         miss_tally   <= 32'h0000_0000;
         hit_ws_tally <= 32'h0000_0000;
         miss_thr     <= 32'h0000_0000;
         hit_thr      <= 32'h0000_0000;
         tint         <= 19'h00000;
         tint_cnt     <= 19'h00000;
         ref_acc      <= 7'h00;
         mon_ctrl     <= 5'h00;
         MONITOR_IRQ  <= 1'b0;
      end else if (CE) begin
         if (w_hit)
            hit_tally <= PWDATA;
         else if (count_hit)
            hit_tally <= hit_next;
         if (w_miss)
            miss_tally <= PWDATA;
         else if (count_miss)
            miss_tally <= miss_next;
         if (w_hws)
            hit_ws_tally <= PWDATA;
         else if (count_ws)
            hit_ws_tally <= bump(hit_ws_tally);
         if (w_mthr)
            miss_thr <= PWDATA;
         if (w_hthr)
            hit_thr <= PWDATA;
         if (w_tint)
            tint <= PWDATA[`CCC_TINT_W-1:0];
         ref_acc <= next_ref_acc;
         if (!run)
            tint_cnt <= tint;
         else if (ref_tick && tint_cnt != 0)
            tint_cnt <= tint_cnt - 19'h00001;
         // Software write first, hardware set wins over a clear
         if (w_mon)
            mon_ctrl <= PWDATA[`CCC_MON_W-1:0];
         if (tint_expire) begin
            mon_ctrl[`CCC_MON_RUN]     <= 1'b0;
            mon_ctrl[`CCC_MON_TINT_ST] <= 1'b1;
         end
         if (hit_thr_evt)
            mon_ctrl[`CCC_MON_HIT_ST] <= 1'b1;
         if (miss_thr_evt)
            mon_ctrl[`CCC_MON_MISS_ST] <= 1'b1;
         MONITOR_IRQ <= mon_ctrl[`CCC_MON_MASK] &
                        (tint_expire | hit_thr_evt | miss_thr_evt);
      end
   end

   // ==========================================================
   // Control register, region configuration, debug reset request
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         CTRL_TWO        <= 27'h0000000;
         qspi_cfg        <= `CCC_QSPI_CFG_RST;
         emb_cfg         <= `CCC_EMB_CFG_RST;
         DEBUG_RESET_REQ <= 1'b0;
      end else if (CE) begin
         // Bits 13, 12, 10 and 9 drive refill, gating and RAM write paths
         if (w_ctrl)
            CTRL_TWO <= PWDATA[`CCC_CTRL_W-1:0];
         if (w_qcfg)
            qspi_cfg <= PWDATA & `CCC_CFG_RSV_MASK;
         if (w_ecfg)
            emb_cfg <= PWDATA & `CCC_CFG_RSV_MASK;
         DEBUG_RESET_REQ <= w_dbg & PWDATA[0];
      end
   end

   // ==========================================================
   // Flush sequencer and readiness
   wire selector_fall = selector_prev & ~STORE_RAM_SELECTOR;
   wire flush_start = selector_fall & ~CTRL_TWO[`CCC_FLUSH_DIS];
   wire flush_last  = FLUSH_ACTIVE &
                      (flush_cnt == `CCC_FLUSH_CYCLES - 9'd1);

   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         FLUSH_ACTIVE  <= 1'b1;
         flush_cnt     <= 9'h000;
         FLUSH_INDEX   <= 8'h00;
         initialised   <= 1'b0;
         selector_prev <= 1'b0;
         CACHE_READY   <= 1'b0;
      end else if (CE) begin
         selector_prev <= STORE_RAM_SELECTOR;
         if (flush_start) begin
            FLUSH_ACTIVE <= 1'b1;
            flush_cnt    <= 9'h000;
         end else if (flush_last) begin
            FLUSH_ACTIVE <= 1'b0;
            initialised  <= 1'b1;
         end else if (FLUSH_ACTIVE) begin
            flush_cnt <= flush_cnt + 9'd1;
         end
         FLUSH_INDEX <= flush_start ? 8'h00 : flush_cnt[7:0];
         CACHE_READY <= CACHE_ENABLE & initialised & ~FLUSH_ACTIVE &
                        ~flush_start & ~flush_last;
      end
   end

   // ==========================================================
   // Lookup result and mirrored RAM access gating
   wire [1:0] busw = CTRL_TWO[`CCC_BUSW_HI:`CCC_BUSW_LO];
   wire size_ok = (busw == `CCC_BUSW_NORMAL) |
                  (((busw == `CCC_BUSW_LOWER) | (busw == `CCC_BUSW_UPPER)) &
                   (~MIRROR_WRITE | (MIRROR_SIZE == `CCC_SIZE_WORD)));
   wire mirror_ok = ~STORE_RAM_SELECTOR &
                    (MIRROR_ADDR < `CCC_MIRROR_LIMIT) &
                    (~MIRROR_WRITE | CTRL_TWO[`CCC_RAM_WEN]) &
                    size_ok;

   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         CACHEABLE    <= 1'b0;
         QSPI_SELECT  <= 1'b0;
         MIRROR_ALLOW <= 1'b0;
         MIRROR_ERROR <= 1'b0;
      end else if (CE) begin
         CACHEABLE    <= LOOKUP_VALID & lookup_cacheable;
         QSPI_SELECT  <= LOOKUP_VALID & in_qspi;
         MIRROR_ALLOW <= MIRROR_VALID & mirror_ok;
         MIRROR_ERROR <= MIRROR_VALID & ~mirror_ok;
      end
   end

endmodule
`default_nettype wire

/* File: hdl/ccc_defs.vh */
/*
 Register map, field positions, reset values and timing figures of the
 processor cache control block. Assumes inclusion by the design file, the checker and the bench.
*/
`ifndef CCC_DEFS_VH
`define CCC_DEFS_VH

// ==========================================================
// Register byte addresses
`define CCC_A_CTRL_TWO   32'h1a0c0020
`define CCC_A_HIT        32'h1a0c0028
`define CCC_A_MISS       32'h1a0c002c
`define CCC_A_MON_CTRL   32'h1a0c0030
`define CCC_A_TINT       32'h1a0c0034
`define CCC_A_MISS_THR   32'h1a0c0038
`define CCC_A_HIT_THR    32'h1a0c003c
`define CCC_A_QSPI_CFG   32'h1a0c0040
`define CCC_A_EMB_CFG    32'h1a0c0044
`define CCC_A_HIT_WS     32'h1a0c0048
`define CCC_A_DBG_RST    32'h1a0c0050

// ==========================================================
// Control register two fields
`define CCC_READY_BIT    28
`define CCC_FLUSH_BIT    27
`define CCC_CTRL_W       27
`define CCC_EMB_LEN_HI   25
`define CCC_EMB_LEN_LO   17
`define CCC_FLUSH_DIS    16
`define CCC_BUSW_HI      15
`define CCC_BUSW_LO      14
`define CCC_IGN_CLKG     13
`define CCC_LIN_REFILL   12
`define CCC_CLK_GATE     10
`define CCC_RAM_WEN      9
`define CCC_QSPI_LEN_HI  8
`define CCC_QSPI_LEN_LO  0

// Bus width selections
`define CCC_BUSW_NORMAL  2'h0
`define CCC_BUSW_LOWER   2'h1
`define CCC_BUSW_UPPER   2'h2

// ==========================================================
// Monitor control fields
`define CCC_MON_W        5
`define CCC_MON_HIT_ST   4
`define CCC_MON_MISS_ST  3
`define CCC_MON_TINT_ST  2
`define CCC_MON_MASK     1
`define CCC_MON_RUN      0
`define CCC_TINT_W       19

// ==========================================================
// Region configuration
`define CCC_QSPI_CFG_RST 32'h16000006
`define CCC_EMB_CFG_RST  32'h00a00006
`define CCC_CFG_RSV_MASK 32'hfffffff7

// ==========================================================
// Timing and sizes
`define CCC_FLUSH_CYCLES 9'd256
`define CCC_CLK_MHZ      7'd100
`define CCC_REF_MHZ      7'd32
`define CCC_MIRROR_LIMIT 16'h2000
`define CCC_SIZE_WORD    2'h2
`define CCC_WORD_STRB    4'hf

`endif

/* File: testbench/ccc_ctrl_props.sv */
/*
 Checker of the cache control block, bound to its ports.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ccc_defs.vh"
module ccc_ctrl_props (
   input wire logic        CLK,
   input wire logic        RST_B,
   input wire logic        CE,
   input wire logic        PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0]  PSTRB,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        CACHE_ENABLE,
   input wire logic        STORE_RAM_SELECTOR,
   input wire logic        LOOKUP_VALID,
   input wire logic        CACHEABLE,
   input wire logic        MIRROR_VALID,
   input wire logic        MIRROR_WRITE,
   input wire logic [15:0] MIRROR_ADDR,
   input wire logic [1:0]  MIRROR_SIZE,
   input wire logic        MIRROR_ALLOW,
   input wire logic        MIRROR_ERROR,
   input wire logic        CACHE_READY,
   input wire logic        FLUSH_ACTIVE,
   input wire logic [26:0] CTRL_TWO
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B || !CE);
   // ==========================================================
   // Helpers
   logic [9:0]  run_len;
   logic [31:0] wd_q;
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B)
         run_len <= 10'h0;
      else if (!FLUSH_ACTIVE)
         run_len <= 10'h0;
      else if (CE)
         run_len <= run_len + 10'h1;
   end
   always @(posedge CLK) begin
      wd_q <= PWDATA;
   end
   // ==========================================================
   // Properties
   property p_flush_len;
      $fell(FLUSH_ACTIVE) |-> run_len == 10'd256;
   endproperty
   a_flush_len: assert property (p_flush_len)
      else $error("flush length");
   property p_rdy;
      FLUSH_ACTIVE || !CACHE_ENABLE |=> !CACHE_READY;
   endproperty
   a_rdy: assert property (p_rdy)
      else $error("ready too early");
   property p_narrow;
      PREADY && PWRITE && PSTRB != `CCC_WORD_STRB |-> PSLVERR;
   endproperty
   a_narrow: assert property (p_narrow)
      else $error("narrow write taken");
   property p_ctl;
      PREADY && PWRITE && PADDR == `CCC_A_CTRL_TWO && !PSLVERR |=>
         CTRL_TWO[25:12] == wd_q[25:12] && CTRL_TWO[10:0] == wd_q[10:0];
   endproperty
   a_ctl: assert property (p_ctl)
      else $error("control write lost");
   property p_nolen;
      !LOOKUP_VALID || (CTRL_TWO[8:0] == 9'h0 && CTRL_TWO[25:17] == 9'h0)
         |=> !CACHEABLE;
   endproperty
   a_nolen: assert property (p_nolen)
      else $error("cacheable without window");
   property p_mir_rng;
      MIRROR_VALID && (MIRROR_ADDR >= 16'h2000 || STORE_RAM_SELECTOR)
         |=> MIRROR_ERROR && !MIRROR_ALLOW;
   endproperty
   a_mir_rng: assert property (p_mir_rng)
      else $error("mirror range");
   property p_mir_wen;
      MIRROR_VALID && MIRROR_WRITE && !CTRL_TWO[9] |=> MIRROR_ERROR;
   endproperty
   a_mir_wen: assert property (p_mir_wen)
      else $error("mirror write protect");
   property p_mir_w;
      MIRROR_VALID && MIRROR_WRITE && CTRL_TWO[15:14] != 2'h0 &&
         MIRROR_SIZE != 2'h2 |=> MIRROR_ERROR;
   endproperty
   a_mir_w: assert property (p_mir_w)
      else $error("mirror narrow write");
   property p_selfall;
      $fell(STORE_RAM_SELECTOR) && !CTRL_TWO[16] |-> ##[1:2] FLUSH_ACTIVE;
   endproperty
   a_selfall: assert property (p_selfall)
      else $error("no flush on selector fall");
endmodule
`default_nettype wire

/* File: testbench/ccc_far_model.sv */
/*
 Processor side model: issues cache lookups and mirror accesses.
 Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/10ps
`default_nettype none
module ccc_far_model (
   input  wire logic  clk,
   output logic        valid,
   output logic [31:0] addr,
   output logic        hit,
   output logic        hit_ws,
   output logic        mvalid,
   output logic        mwrite,
   output logic [15:0] maddr,
   output logic [1:0]  msize
);
   initial begin
      {valid, hit, hit_ws, mvalid, mwrite} = 5'h0;
      addr = 32'h0;
      maddr = 16'h0;
      msize = 2'h2;
   end
   task send(input logic [31:0] a, input logic h);
      @(posedge clk);
      valid <= 1'b1;
      addr <= a;
      hit <= h;
      hit_ws <= h & a[2];
      @(posedge clk);
      valid <= 1'b0;
      addr <= ~a;
      hit <= ~h;
      hit_ws <= 1'b0;
   endtask
   task mir(input logic wr, input logic [15:0] a, input logic [1:0] z);
      @(posedge clk);
      mvalid <= 1'b1;
      mwrite <= wr;
      maddr <= a;
      msize <= z;
      @(posedge clk);
      mvalid <= 1'b0;
      maddr <= ~a;
      msize <= ~z;
   endtask
endmodule
`default_nettype wire

/* File: testbench/ccc_ctrl_tb.sv */
/*
 Self-checking bench of the cache control block.
 Assumes the checker and the processor side model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ccc_defs.vh"
module ccc_ctrl_tb;
   logic        clk, rst_b, ce, psel, penable, pwrite, en, sel, er;
   logic [31:0] paddr, pwdata, rd, seed, a, v, hx, mx;
   logic [3:0]  pstrb;
   logic [15:0] ma;
   logic [1:0]  w, z;
   wire logic [31:0] prdata, la;
   wire logic [26:0] ctl;
   wire logic [15:0] mad;
   wire logic [1:0]  msz;
   wire logic prdy, perr, lv, lh, lw, co, mv, mw, mal, mer, rdy, fl, irq;
   wire logic qs, dbg;
   int n_mismatch, n_compared, n, i, cyc;
   ccc_ctrl DUT (.CLK(clk), .RST_B(rst_b), .CE(ce), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PSTRB(pstrb), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr),
      .CACHE_ENABLE(en), .STORE_RAM_SELECTOR(sel), .LOOKUP_VALID(lv),
      .LOOKUP_ADDR(la), .LOOKUP_HIT(lh), .LOOKUP_HIT_WS(lw),
      .CACHEABLE(co), .QSPI_SELECT(qs), .MIRROR_VALID(mv),
      .MIRROR_WRITE(mw), .MIRROR_ADDR(mad), .MIRROR_SIZE(msz),
      .MIRROR_ALLOW(mal), .MIRROR_ERROR(mer), .CACHE_READY(rdy),
      .FLUSH_ACTIVE(fl), .FLUSH_INDEX(), .MONITOR_IRQ(irq),
      .DEBUG_RESET_REQ(dbg), .CTRL_TWO(ctl));
   ccc_far_model PM (.clk(clk), .valid(lv), .addr(la), .hit(lh),
      .hit_ws(lw), .mvalid(mv), .mwrite(mw), .maddr(mad), .msize(msz));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic cab(input logic [31:0] a);
      return (a - 32'h16000000) < 32'h10000 || (a - 32'h00a00000) < 32'h20000;
   endfunction
   function automatic logic mok(input logic [1:0] w, input logic we, s,
                                input logic wr, input logic [15:0] a,
                                input logic [1:0] z);
      return !s && a < 16'h2000 && w != 2'h3 &&
             (!wr || (we && (w == 2'h0 || z == 2'h2)));
   endfunction
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [31:0] ad, d, input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [31:0] ad, d);
      apb(1'b1, ad, d, 4'hf);
   endtask
   task rdc(input logic [31:0] ad, exp);
      apb(1'b0, ad, 32'h0, 4'hf);
      chk(rd, exp);
   endtask
   task wait_flush;
      n = 0;
      while (fl === 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         end_sim;
      end
   end
   // ==========================================================
   // Sequence
   initial begin
      {psel, penable, pwrite, sel, rst_b} = 5'h0;
      {ce, en} = 2'h3;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      seed = 32'h1145;
      repeat (16) @(posedge clk);
      chk(fl, 1);
      chk(rdy, 0);
      rst_b <= 1'b1;
      wait_flush;
      chk(n, `CCC_FLUSH_CYCLES + 1);
      @(posedge clk);
      #1 chk(rdy, 1);
      $display("test reset done");
      rdc(`CCC_A_CTRL_TWO, 32'h10000000);
      rdc(`CCC_A_MISS, 0);
      rdc(`CCC_A_QSPI_CFG, `CCC_QSPI_CFG_RST);
      wr(`CCC_A_DBG_RST, 32'h1);
      #1 chk(dbg, 1);
      rdc(`CCC_A_DBG_RST, 0);
      rdc(32'h1a0c0024, 0);
      chk(er, 1);
      apb(1'b1, `CCC_A_HIT, 32'h5, 4'h3);
      chk(er, 1);
      rdc(`CCC_A_HIT, 0);
      for (i = 0; i < 6; i++) begin
         seed = xs(seed);
         v = seed & 32'h03fff7ff;
         wr(`CCC_A_CTRL_TWO, v);
         rdc(`CCC_A_CTRL_TWO, v | 32'h10000000);
         chk(ctl, v[26:0]);
      end
      $display("test registers done");
      hx = xs(seed);
      mx = xs(hx);
      wr(`CCC_A_HIT, hx);
      wr(`CCC_A_MISS, mx);
      wr(`CCC_A_CTRL_TWO, {6'h0, 9'd2, 8'h0, 9'd1});
      wr(`CCC_A_MON_CTRL, 32'h1);
      for (i = 0; i < 30; i++) begin
         seed = xs(seed);
         a = (seed[0] ? 32'h16000000 : 32'h00a00000) + {13'h0, seed[18:0]};
         if (i < 4) a = i[1] ? 32'h1600fffc : 32'h00a1fffc;
         PM.send(a, seed[5]);
         #1 chk(co, cab(a));
         chk(qs, (a - 32'h16000000) < 32'h10000);
         if (cab(a)) begin
            hx = hx + seed[5];
            mx = mx + !seed[5];
         end
      end
      wr(`CCC_A_MON_CTRL, 32'h0);
      PM.send(32'h16000000, 1'b1);
      rdc(`CCC_A_HIT, hx);
      rdc(`CCC_A_MISS, mx);
      $display("test windows done");
      wr(`CCC_A_TINT, 32'h5);
      wr(`CCC_A_MON_CTRL, 32'h3);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(irq, 1);
      rdc(`CCC_A_MON_CTRL, 32'h6);
      $display("test interval done");
      for (i = 0; i < 2; i++) begin
         wr(`CCC_A_CTRL_TWO, i ? 32'h10000 : 32'h0);
         sel <= 1'b1;
         repeat (2) @(posedge clk);
         sel <= 1'b0;
         repeat (3) @(posedge clk);
         chk(fl, !i);
         wait_flush;
      end
      $display("test flush done");
      for (i = 0; i < 16; i++) begin
         seed = xs(seed);
         w = i[1:0];
         z = seed[5:4] == 2'h3 ? 2'h2 : seed[5:4];
         ma = seed[1] & seed[2] ? 16'h2000 : {1'b0, seed[14:2], 2'h0};
         wr(`CCC_A_CTRL_TWO, {16'h1, w, 4'h0, seed[0], 9'h0});
         sel <= (i == 7);
         PM.mir(seed[3], ma, z);
         #1 chk(mal, mok(w, seed[0], i == 7, seed[3], ma, z));
         chk(mer, !mok(w, seed[0], i == 7, seed[3], ma, z));
      end
      $display("test mirror done");
      en <= 1'b0;
      repeat (2) @(posedge clk);
      chk(rdy, 0);
      end_sim;
   end
endmodule
bind ccc_ctrl ccc_ctrl_props u_props (.CLK(CLK), .RST_B(RST_B), .CE(CE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .CACHE_ENABLE(CACHE_ENABLE),
   .STORE_RAM_SELECTOR(STORE_RAM_SELECTOR), .LOOKUP_VALID(LOOKUP_VALID),
   .CACHEABLE(CACHEABLE), .MIRROR_VALID(MIRROR_VALID),
   .MIRROR_WRITE(MIRROR_WRITE), .MIRROR_ADDR(MIRROR_ADDR),
   .MIRROR_SIZE(MIRROR_SIZE), .MIRROR_ALLOW(MIRROR_ALLOW),
   .MIRROR_ERROR(MIRROR_ERROR), .CACHE_READY(CACHE_READY),
   .FLUSH_ACTIVE(FLUSH_ACTIVE), .CTRL_TWO(CTRL_TWO));
`default_nettype wire
